// File: hdl/dsh_device.sv
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// [R01] Standalone: sync fall starts write, clears count
// [R02] Standalone: ignore sclk after 24, sync rises
// [R03] New word needs fresh sync falling edge
// [R04] Chain mode shifts every sclk while sync low
// [R05] Chain: bits beyond 24 ripple out on sdo
// [R06] Sdo changes on sclk rise, sampled on fall
// [R07] Host sends 24 clocks per chained device
// [R08] Sync rise latches word, stops shifting
// [R09] Sync rise before 24 clocks: bad frame; only chain mode flags it, standalone keeps shifting
// [R10] Gated burst exact, sync rises after last
// [R11] Read bit set selects register for readback
// [R12] Next frame sdo: echoed header plus data
// [R13] Sclk idling high: first bit at sync fall
// [R14] Select low: I2C slave, never drives clock
// [R15] Slave address 10101 plus two strap pins
// [R16] Sda fall/rise with scl high: start/stop
// [R17] Repeated start keeps transaction active
// [R18] Master holds sda stable while scl high
// [R19] Ack each byte: sda low, ninth clock
// [R20] Idle waits start plus own address, acks match
// [R21] Master sends read/write bit zero
// [R22] Master checks acks, retries on failure; the host only sets the nack status bit and does not retry
// [R23] Word: toggle, rw, 00, channel, register, data
// [R24] Shift din msb first on sclk falls
module dsh_device (
   input wire logic clk_i,
   input wire logic rst_i,
   dsh_link_if.device link,
   input wire logic iface_sel_i,
   input wire logic chain_enable_i,
   input wire logic bus_addr_strap_hi_i,
   input wire logic bus_addr_strap_lo_i,
   input wire logic [dsh_pkg::RB_DATA_W-1:0] rb_data_i,
   output logic [dsh_pkg::WORD_W-1:0] word_o,
   output logic word_valid_o,
   output logic bad_frame_o,
   output logic [dsh_pkg::SEL_W-1:0] rb_sel_o,
   output logic [7:0] rx_byte_o,
   output logic rx_byte_valid_o
);
   logic [8:0] meta;
   logic [8:0] pins;
   logic [8:0] pins_d;
   logic sync_n;
   logic sclk;
   logic din;
   logic spi_mode;
   logic chain;
   logic sync_fall;
   logic sync_rise;
   logic sclk_fall;
   logic sclk_rise;
   logic scl_high;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic frame;
   logic [4:0] cnt;
   logic [dsh_pkg::WORD_W-1:0] in_sr;
   logic [dsh_pkg::WORD_W-1:0] out_sr;
   logic [dsh_pkg::WORD_W-1:0] shifted;
   logic [dsh_pkg::WORD_W-1:0] next_word;
   logic [dsh_pkg::WORD_W-1:0] rb_word;
   logic [dsh_pkg::HDR_W-1:0] rb_hdr;
   logic rb_pend;
   logic take_sa;
   logic take_dc;
   logic take;
   logic sdo;
   dsh_pkg::dsh_i2c_state_t state;
   logic [3:0] bitc;
   logic [7:0] sh;
   logic sda_oe;

   // Every pin passes two flops; only pins and pins_d are read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= dsh_pkg::PIN_IDLE;
         pins <= dsh_pkg::PIN_IDLE;
         pins_d <= dsh_pkg::PIN_IDLE;
      end else begin
         meta <= {link.sync_n, link.sclk, link.din, link.scl, link.sda, iface_sel_i,
                  chain_enable_i, bus_addr_strap_hi_i, bus_addr_strap_lo_i};
         pins <= meta;
         pins_d <= pins;
      end
   end

   assign sync_n = pins[8];
   assign sclk = pins[7];
   assign din = pins[6];
   assign spi_mode = pins[3];
   assign chain = pins[2];
   assign sync_fall = pins_d[8] & ~sync_n;
   assign sync_rise = ~pins_d[8] & sync_n;
   assign sclk_fall = pins_d[7] & ~sclk;
   assign sclk_rise = ~pins_d[7] & sclk;
   assign scl_high = pins_d[5] & pins[5];
   assign scl_rise = ~pins_d[5] & pins[5];
   assign scl_fall = pins_d[5] & ~pins[5];
   assign start_c = scl_high & pins_d[4] & ~pins[4]; // R16
   assign stop_c = scl_high & ~pins_d[4] & pins[4]; // R16

   assign shifted = {in_sr[dsh_pkg::WORD_W-2:0], din}; // R24
   assign take_sa = frame & ~chain & sclk_fall & (cnt == dsh_pkg::LAST_BIT);
   assign take_dc = frame & chain & sync_rise & (cnt == dsh_pkg::WORD_BITS); // R08
   assign take = take_sa | take_dc;
   assign next_word = take_sa ? shifted : in_sr;
   assign rb_word = rb_pend ? {rb_hdr, rb_data_i} : '0; // R12

   // Frame tracking and input shift register
   always_ff @(posedge clk_i) begin
      if (rst_i || !spi_mode) begin
         frame <= 1'b0;
         cnt <= 5'h00;
         in_sr <= '0;
      end else if (sync_fall) begin
         frame <= 1'b1; // R01 R03
         cnt <= 5'h00; // R01
      end else if (frame && chain && sync_rise) begin
         frame <= 1'b0; // R08
      end else if (frame && sclk_fall && (chain || !sync_n || cnt != dsh_pkg::WORD_BITS)) begin
         // Standalone keeps shifting past a stray sync rise
         in_sr <= shifted; // R04 R24
         if (cnt != dsh_pkg::WORD_BITS) begin
            cnt <= cnt + 5'h01;
         end
         if (take_sa) begin
            frame <= 1'b0; // R02
         end
      end
   end

   // Word hand-off and bad frame report
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_o <= '0;
         word_valid_o <= 1'b0;
         bad_frame_o <= 1'b0;
      end else begin
         word_valid_o <= take;
         bad_frame_o <= frame & chain & sync_rise & (cnt != dsh_pkg::WORD_BITS); // R09
         if (take) begin
            word_o <= next_word;
         end
      end
   end

   // Readback request held until the next frame opens
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rb_pend <= 1'b0;
         rb_hdr <= '0;
         rb_sel_o <= '0;
      end else if (take) begin
         rb_pend <= next_word[dsh_pkg::RW_POS]; // R11
         if (next_word[dsh_pkg::RW_POS]) begin
            rb_hdr <= next_word[dsh_pkg::WORD_W-1 -: dsh_pkg::HDR_W]; // R12 R23
            rb_sel_o <= next_word[dsh_pkg::SEL_LSB +: dsh_pkg::SEL_W]; // R11 R23
         end
      end else if (sync_fall) begin
         rb_pend <= 1'b0;
      end
   end

   // Serial output
   always_ff @(posedge clk_i) begin
      if (rst_i || !spi_mode) begin
         sdo <= 1'b0;
         out_sr <= '0;
      end else if (sync_fall) begin
         if (sclk) begin
            sdo <= rb_word[dsh_pkg::WORD_W-1]; // R13
            out_sr <= {rb_word[dsh_pkg::WORD_W-2:0], 1'b0};
         end else begin
            out_sr <= rb_word;
         end
      end else if (frame && sclk_rise) begin
         if (chain && cnt == dsh_pkg::WORD_BITS) begin
            sdo <= in_sr[dsh_pkg::WORD_W-1]; // R05 R06
         end else begin
            sdo <= out_sr[dsh_pkg::WORD_W-1]; // R06 R12
            out_sr <= {out_sr[dsh_pkg::WORD_W-2:0], 1'b0};
         end
      end
   end

   assign link.sdo = sdo;
   // Only sda is ever pulled; scl has no driver here
   assign link.dev_sda_oe = sda_oe; // R14

   // Receive-only bus slave
   always_ff @(posedge clk_i) begin
      if (rst_i || spi_mode) begin
         state <= dsh_pkg::DSH_IDLE; // R14
         bitc <= 4'h0;
         sh <= 8'h00;
         sda_oe <= 1'b0;
         rx_byte_o <= 8'h00;
         rx_byte_valid_o <= 1'b0;
      end else begin
         rx_byte_valid_o <= 1'b0;
         if (start_c) begin
            state <= dsh_pkg::DSH_ADDR; // R17 R20
            bitc <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            state <= dsh_pkg::DSH_IDLE; // R16
            sda_oe <= 1'b0;
         end else begin
            case (state)
               dsh_pkg::DSH_ADDR, dsh_pkg::DSH_DATA: begin
                  if (scl_rise) begin
                     sh <= {sh[6:0], pins[4]};
                     bitc <= bitc + 4'h1;
                  end else if (scl_fall && bitc == dsh_pkg::BYTE_BITS) begin
                     if (state == dsh_pkg::DSH_DATA) begin
                        sda_oe <= 1'b1; // R19
                        rx_byte_o <= sh;
                        rx_byte_valid_o <= 1'b1;
                        state <= dsh_pkg::DSH_DATA_ACK;
                     end else if (sh == {dsh_pkg::BUS_ADDR_FIXED, pins[1:0], 1'b0}) begin
                        // A read request is never acknowledged
                        sda_oe <= 1'b1; // R15 R19 R20 R21
                        state <= dsh_pkg::DSH_ADDR_ACK;
                     end else begin
                        state <= dsh_pkg::DSH_IDLE; // R20
                     end
                  end
               end
               dsh_pkg::DSH_ADDR_ACK, dsh_pkg::DSH_DATA_ACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0; // R19
                     bitc <= 4'h0;
                     state <= dsh_pkg::DSH_DATA;
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : dsh_device

// File: hdl/dsh_pkg.sv
package dsh_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int WORD_W = 24;
   localparam int RB_DATA_W = 14;
   localparam int HDR_W = 10;
   localparam int RW_POS = 22;
   localparam int SEL_LSB = 14;
   localparam int SEL_W = 6;
   localparam logic [4:0] WORD_BITS = 5'h18;
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam logic [4:0] BUS_ADDR_FIXED = 5'h15;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Pin sample vector idle value: sync_n, sclk, din, scl, sda, sel, chain, straps
   localparam logic [8:0] PIN_IDLE = 9'h1b0;
   // Host link timing: half period of the generated serial clocks
   localparam int HALF_NS = 200;
   localparam int HALF_CYC = (HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
   localparam logic [5:0] SER_LAST = 6'h31;
   localparam logic [5:0] I2C_STOP_LOW = 6'h37;
   localparam logic [5:0] I2C_STOP_SCL = 6'h38;
   localparam logic [5:0] I2C_LAST = 6'h39;
   localparam logic [26:0] I2C_ACK_MASK = 27'h0040201;
   // Host register map, byte addresses
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_TX = 4'h4;
   localparam logic [3:0] ADR_RX = 4'h8;
   localparam logic [3:0] ADR_STAT = 4'hc;
   localparam int CTRL_SER_GO = 0;
   localparam int CTRL_I2C_GO = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_NACK = 1;
   localparam logic [23:0] TX_RESET = 24'h000000;
   localparam logic [23:0] RX_RESET = 24'h000000;
   typedef enum logic [2:0] {
      DSH_IDLE = 3'b000,
      DSH_ADDR = 3'b001,
      DSH_ADDR_ACK = 3'b011,
      DSH_DATA = 3'b010,
      DSH_DATA_ACK = 3'b110
   } dsh_i2c_state_t;
   typedef enum logic [1:0] {
      DSH_H_IDLE = 2'b00,
      DSH_H_SER = 2'b01,
      DSH_H_I2C = 2'b11
   } dsh_host_state_t;
endpackage : dsh_pkg

// File: hdl/dsh_link_if.sv
`timescale 1ns/1ps
interface dsh_link_if;
   logic sync_n;
   logic sclk;
   logic din;
   logic sdo;
   logic scl_oe;
   logic host_sda_oe;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // Open-drain wires with pull-ups
   assign scl = ~scl_oe;
   assign sda = ~(host_sda_oe | dev_sda_oe);
   modport device(input sync_n, sclk, din, scl, sda, output sdo, dev_sda_oe);
   modport host(input sdo, sda, output sync_n, sclk, din, scl_oe, host_sda_oe);
endinterface : dsh_link_if

// File: hdl/dsh_host.sv
`timescale 1ns/1ps
module dsh_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   dsh_link_if.host link
);
   logic [1:0] meta;
   logic [1:0] pins;
   logic req;
   logic wr;
   logic [23:0] tx;
   logic [23:0] rx;
   logic [26:0] sh;
   logic [26:0] ackm;
   logic ackcur;
   logic nack;
   dsh_pkg::dsh_host_state_t state;
   logic [5:0] step;
   logic [5:0] next_step;
   logic [3:0] hcnt;
   logic tick;
   logic sync_n;
   logic sclk;
   logic din;
   logic scl_oe;
   logic sda_oe;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 2'h1;
         pins <= 2'h1;
      end else begin
         meta <= {link.sdo, link.sda};
         pins <= meta;
      end
   end

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // A write lands at the edge where the master sees ack high
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         if (req) begin
            case (wb_adr_i)
               dsh_pkg::ADR_TX: wb_dat_o <= {8'h00, tx};
               dsh_pkg::ADR_RX: wb_dat_o <= {8'h00, rx};
               dsh_pkg::ADR_STAT: wb_dat_o <= {30'h0, nack, state != dsh_pkg::DSH_H_IDLE};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // Word is only rewritten while idle so a transfer sees stable data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx <= dsh_pkg::TX_RESET;
      end else if (wr && wb_adr_i == dsh_pkg::ADR_TX && state == dsh_pkg::DSH_H_IDLE) begin
         for (int i = 0; i < 3; i++) begin
            if (wb_sel_i[i]) begin
               tx[8*i +: 8] <= wb_dat_i[8*i +: 8];
            end
         end
      end
   end

   assign tick = hcnt == dsh_pkg::HALF_LAST;
   assign next_step = step + 6'h01;

   always_ff @(posedge clk_i) begin
      if (rst_i || state == dsh_pkg::DSH_H_IDLE) begin
         hcnt <= 4'h0;
      end else begin
         hcnt <= tick ? 4'h0 : hcnt + 4'h1;
      end
   end

   // Transfer engine: one step per half period of the link clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= dsh_pkg::DSH_H_IDLE;
         step <= 6'h00;
         sync_n <= 1'b1;
         sclk <= 1'b1;
         din <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         sh <= '0;
         ackm <= '0;
         ackcur <= 1'b0;
         nack <= 1'b0;
         rx <= dsh_pkg::RX_RESET;
      end else begin
         case (state)
            dsh_pkg::DSH_H_IDLE: begin
               step <= 6'h00;
               if (wr && wb_adr_i == dsh_pkg::ADR_CTRL && wb_sel_i[0]) begin
                  if (wb_dat_i[dsh_pkg::CTRL_SER_GO]) begin
                     state <= dsh_pkg::DSH_H_SER;
                     sync_n <= 1'b0; // R03
                     din <= tx[23];
                     sh <= {tx[22:0], 3'h0, 1'b0};
                  end else if (wb_dat_i[dsh_pkg::CTRL_I2C_GO]) begin
                     state <= dsh_pkg::DSH_H_I2C;
                     nack <= 1'b0;
                     sda_oe <= 1'b1; // R16
                     sh <= {tx[23:16], 1'b1, tx[15:8], 1'b1, tx[7:0], 1'b1};
                     ackm <= dsh_pkg::I2C_ACK_MASK;
                  end
               end
            end
            dsh_pkg::DSH_H_SER: begin
               if (tick) begin
                  step <= next_step;
                  if (next_step == dsh_pkg::SER_LAST) begin
                     sync_n <= 1'b1; // R07 R10
                     state <= dsh_pkg::DSH_H_IDLE;
                  end else if (next_step[0]) begin
                     sclk <= 1'b0;
                     rx <= {rx[22:0], pins[1]}; // R06
                  end else begin
                     sclk <= 1'b1;
                     din <= sh[26];
                     sh <= {sh[25:0], 1'b0};
                  end
               end
            end
            dsh_pkg::DSH_H_I2C: begin
               if (tick) begin
                  step <= next_step;
                  if (next_step[0] && step != 6'h00 && ackcur && pins[0]) begin
                     nack <= 1'b1; // R22
                  end
                  if (next_step == dsh_pkg::I2C_STOP_LOW) begin
                     scl_oe <= 1'b1;
                     sda_oe <= 1'b1;
                     ackcur <= 1'b0;
                  end else if (next_step == dsh_pkg::I2C_STOP_SCL) begin
                     scl_oe <= 1'b0;
                  end else if (next_step == dsh_pkg::I2C_LAST) begin
                     sda_oe <= 1'b0; // R16
                     state <= dsh_pkg::DSH_H_IDLE;
                  end else if (next_step[0]) begin
                     // Sda only moves while scl is low
                     scl_oe <= 1'b1; // R18
                     sda_oe <= ~sh[26]; // R21
                     ackcur <= ackm[26];
                     sh <= {sh[25:0], 1'b0};
                     ackm <= {ackm[25:0], 1'b0};
                  end else begin
                     scl_oe <= 1'b0;
                  end
               end
            end
            default: begin
               state <= dsh_pkg::DSH_H_IDLE;
            end
         endcase
      end
   end

   assign link.sync_n = sync_n;
   assign link.sclk = sclk;
   assign link.din = din;
   assign link.scl_oe = scl_oe;
   assign link.host_sda_oe = sda_oe;
endmodule : dsh_host

// File: test/dsh_link_monitor.sv
`timescale 1ns/1ps
module dsh_link_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sync_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic sdo,
   input wire logic scl,
   input wire logic dev_sda_oe
);
   logic prev_sclk;
   logic prev_sync;
   logic [5:0] fall_cnt;
   logic [3:0] since_edge;
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_sclk <= 1'b1;
         prev_sync <= 1'b1;
      end else begin
         prev_sclk <= sclk;
         prev_sync <= sync_n;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || (prev_sync && !sync_n)) begin
         fall_cnt <= 6'h00;
      end else if (prev_sclk && !sclk && !sync_n) begin
         fall_cnt <= fall_cnt + 6'h01;
      end
   end
   // Saturates so a long idle cannot wrap into a false pass
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_edge <= 4'hf;
      end else if ((sclk && !prev_sclk) || (prev_sync && !sync_n)) begin
         since_edge <= 4'h0;
      end else if (since_edge != 4'hf) begin
         since_edge <= since_edge + 4'h1;
      end
   end
   AST_SDO_AFTER_RISE: assert property ($changed(sdo) |-> since_edge <= 4'h8)
      else $error("sdo changed away from a clock rise or frame start");
   AST_SDO_AT_FALL: assert property ($fell(sclk) |-> $stable(sdo))
      else $error("sdo moved at a sampling fall");
   AST_DIN_AT_FALL: assert property ($fell(sclk) |-> $stable(din) && !sync_n)
      else $error("din moved at a sampling fall");
   AST_HOST_COUNT: assert property ($rose(sync_n) |-> fall_cnt == 6'h18)
      else $error("frame closed with a wrong clock count");
   AST_HOST_END: assert property ($rose(sync_n) |-> sclk && $past(sclk))
      else $error("frame closed before the last clock ended");
   AST_ACK_SCL_LOW: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 2))
      else $error("ack started while scl high");
   AST_ACK_LEN: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8] ##[2:16] !dev_sda_oe)
      else $error("ack length wrong");
   AST_NO_DEV_COND: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device moved sda while scl high");
   CV_FRAME: cover property ($rose(sync_n));
   CV_ACK: cover property ($rose(dev_sda_oe));
   CV_SDO: cover property ($changed(sdo));
endmodule : dsh_link_monitor

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk_i, rst_i, cyc, stb, we, ack, iface_sel, chain, strap_hi, strap_lo, chain2;
   logic wv, rxv, wv2, bad2;
   logic sel2, rxv2;
   logic [3:0] adr;
   logic [31:0] wdat, rdat, rd;
   logic [13:0] rb_data;
   logic [23:0] word, word2;
   logic [5:0] rb_sel;
   logic [7:0] rx_byte, rx2;
   logic [47:0] got2;
   int bad_count = 0, n_checks = 0, cyc_cnt = 0, n_wv = 0, n_rx = 0, n_wv2 = 0, n_bad2 = 0;
   int n_rx2 = 0;
   dsh_link_if lk();
   dsh_link_if lk2();
   dsh_host dsh_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .link(lk.host));
   dsh_device dsh_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(lk.device),
      .iface_sel_i(iface_sel), .chain_enable_i(chain), .bus_addr_strap_hi_i(strap_hi),
      .bus_addr_strap_lo_i(strap_lo), .rb_data_i(rb_data), .word_o(word),
      .word_valid_o(wv), .bad_frame_o(), .rb_sel_o(rb_sel), .rx_byte_o(rx_byte),
      .rx_byte_valid_o(rxv));
   // Second device faces the bench so frames can break the host's habits
   dsh_device dsh_device_b_i (.clk_i(clk_i), .rst_i(rst_i), .link(lk2.device),
      .iface_sel_i(sel2), .chain_enable_i(chain2), .bus_addr_strap_hi_i(1'b0),
      .bus_addr_strap_lo_i(1'b0), .rb_data_i(rb_data), .word_o(word2),
      .word_valid_o(wv2), .bad_frame_o(bad2), .rb_sel_o(), .rx_byte_o(rx2),
      .rx_byte_valid_o(rxv2));
   dsh_link_monitor dsh_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .sync_n(lk.sync_n),
      .sclk(lk.sclk), .din(lk.din), .sdo(lk.sdo), .scl(lk.scl),
      .dev_sda_oe(lk.dev_sda_oe));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic go(input logic [31:0] ctrl);
      wb(1'b1, dsh_pkg::ADR_CTRL, ctrl);
      do wb(1'b0, dsh_pkg::ADR_STAT, 32'h0); while (rd[dsh_pkg::STAT_BUSY] !== 1'b0);
      // Lets the device's synchronised pulses land before checking
      repeat (8) @(posedge clk_i);
   endtask : go
   task automatic send(input logic [23:0] w);
      wb(1'b1, dsh_pkg::ADR_TX, {8'h00, w});
      go(32'h1);
      wb(1'b0, dsh_pkg::ADR_RX, 32'h0);
   endtask : send
   task automatic i2c(input logic [23:0] t);
      wb(1'b1, dsh_pkg::ADR_TX, {8'h00, t});
      go(32'h2);
      wb(1'b0, dsh_pkg::ADR_STAT, 32'h0);
   endtask : i2c
   task automatic frame2(input logic [47:0] bits, input int n, input int rise_at);
      got2 = '0;
      repeat (4) @(posedge clk_i);
      lk2.sync_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         lk2.din <= bits[47 - i];
         if (i == rise_at) lk2.sync_n <= 1'b1;
         repeat (dsh_pkg::HALF_CYC) @(posedge clk_i);
         lk2.sclk <= 1'b0;
         got2 = {got2[46:0], lk2.sdo};
         repeat (dsh_pkg::HALF_CYC) @(posedge clk_i);
         lk2.sclk <= 1'b1;
      end
      repeat (dsh_pkg::HALF_CYC) @(posedge clk_i);
      lk2.sync_n <= 1'b1;
      repeat (16) @(posedge clk_i);
   endtask : frame2
   // Bus bit with scl low on entry; sda is sampled at the end of scl high
   task automatic bit2(input logic b);
      repeat (4) @(posedge clk_i);
      lk2.host_sda_oe <= ~b;
      repeat (4) @(posedge clk_i);
      lk2.scl_oe <= 1'b0;
      repeat (dsh_pkg::HALF_CYC) @(posedge clk_i);
      got2 = {got2[46:0], lk2.sda};
      lk2.scl_oe <= 1'b1;
   endtask : bit2
   task automatic byte2(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         bit2(b[i]);
      end
      bit2(1'b1);
   endtask : byte2
   // Start (also repeated) when stop is 0, stop otherwise
   task automatic cond2(input logic stop);
      lk2.host_sda_oe <= stop;
      repeat (8) @(posedge clk_i);
      lk2.scl_oe <= 1'b0;
      repeat (8) @(posedge clk_i);
      lk2.host_sda_oe <= ~stop;
      repeat (8) @(posedge clk_i);
      lk2.scl_oe <= ~stop;
   endtask : cond2
   initial begin
      clk_i = 1'b0;
      forever #(dsh_pkg::CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (wv === 1'b1) n_wv++;
      if (rxv === 1'b1) n_rx++;
      if (wv2 === 1'b1) n_wv2++;
      if (bad2 === 1'b1) n_bad2++;
      if (rxv2 === 1'b1) n_rx2++;
      if (cyc_cnt == 30000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      wdat = 32'h0;
      iface_sel = 1'b1;
      chain = 1'b0;
      strap_hi = 1'b0;
      strap_lo = 1'b0;
      chain2 = 1'b1;
      sel2 = 1'b1;
      rb_data = 14'h0;
      lk2.sync_n = 1'b1;
      lk2.sclk = 1'b1;
      lk2.din = 1'b0;
      lk2.scl_oe = 1'b0;
      lk2.host_sda_oe = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b0, dsh_pkg::ADR_TX, 32'h0);
      check(rd, {8'h00, dsh_pkg::TX_RESET});
      wb(1'b0, dsh_pkg::ADR_RX, 32'h0);
      check(rd, {8'h00, dsh_pkg::RX_RESET});
      wb(1'b1, 4'h2, 32'hffffffff);
      wb(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0);
      check(word, 32'h0);
      $display("test reset done");
      send(24'h8f2a5c);
      check(word, 24'h8f2a5c);
      check(rd, 32'h0);
      send(24'h45c123);
      check(rb_sel, 6'h17);
      rb_data <= 14'h2b3c;
      send(24'h000000);
      check(rd, {8'h00, 10'h117, 14'h2b3c});
      send(24'h000000);
      check(rd, 32'h0);
      check(n_wv, 4);
      $display("test serial done");
      iface_sel <= 1'b0;
      send(24'h123456);
      check(n_wv, 4);
      for (int k = 0; k < 4; k++) begin
         {strap_hi, strap_lo} <= k[1:0];
         i2c({5'b10101, k[1:0], 1'b0, 8'ha0 + 8'(k), 8'h3c ^ 8'(k)});
         check(rd, 32'h0);
         check(rx_byte, 8'h3c ^ 8'(k));
      end
      i2c({5'b10101, 2'b00, 1'b0, 16'h5555});
      check(rd, 32'h2);
      i2c({5'b10101, 2'b11, 1'b1, 16'h5555});
      check(rd, 32'h2);
      i2c({5'b10101, 2'b11, 1'b0, 16'h7e81});
      check(rd, 32'h0);
      check(n_rx, 10);
      $display("test bus done");
      frame2({24'hc3a5f0, 24'h5a0f96}, 48, 99);
      check(word2, 24'h5a0f96);
      check(got2[23:0], 24'hc3a5f0);
      frame2({24'h0ff0aa, 24'h0}, 10, 99);
      check(n_bad2, 1);
      check(word2, 24'h5a0f96);
      chain2 <= 1'b0;
      frame2({24'h3c5a69, 24'hffffff}, 30, 99);
      check(word2, 24'h3c5a69);
      frame2({24'h96e187, 24'h0}, 24, 12);
      check(word2, 24'h96e187);
      check(n_wv2, 3);
      $display("test frames done");
      sel2 <= 1'b0;
      repeat (4) @(posedge clk_i);
      cond2(1'b0);
      byte2(8'ha8);
      cond2(1'b0);
      byte2(8'ha8);
      byte2(8'h5b);
      cond2(1'b1);
      check({got2[18], got2[9], got2[0]}, 32'h0);
      check(rx2, 8'h5b);
      check(n_rx2, 1);
      $display("test restart done");
      end_sim();
   end
endmodule : tb
